// >>> rtl/msa_serial_port.sv
`timescale 1ns/1ps
// Functional notes
// - one shared bit clock and frame clock serve all sixteen channels
// - both clocks run synchronous to the audio sample rate
// - after reset framing is I2S, data one bit after frame edge
// - format field also selects left-justified or right-justified 24/16
// - three-bit mode field picks stereo or a multiplexed slot layout
// - control one bits invert bit-clock edge and frame polarity
// - master bit drives both clocks; clear means clocks are inputs
// - 16x1, 8x2, 4x4 or 2x8 slots per data line supported
// - frame clock is a one-bit pulse or a 50% square wave
// - every slot is 16 or 32 bit clocks long in every mode
// - stereo: line n carries channels 2n-1 and 2n
// - four slots: lines 1-4 carry channels in order, 5-8 ignored
// - eight slots: lines 1 and 2 carry 1-8 and 9-16
// - sixteen slots: line 1 alone carries all channels
// - frame pin is frame sync, bit pin bit clock; in or out
// - edge bit set captures data on the falling bit-clock edge
module msa_serial_port #(
    parameter int HALF_CYC = msa_pkg::MSA_HALF_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  dac_control_zero_i,
    input  wire logic [7:0]  dac_control_one_i,
    input  wire logic        dac_bit_clock_i,
    output logic             dac_bit_clock_o,
    output logic             dac_bit_clock_oe_b_o,
    input  wire logic        dac_frame_clock_i,
    output logic             dac_frame_clock_o,
    output logic             dac_frame_clock_oe_b_o,
    input  wire logic [7:0]  serial_data_in_i,
    input  wire logic [3:0]  rd_chan_i,
    output logic [23:0]      rd_data_o,
    output logic             sample_valid_o,
    output logic [3:0]       sample_chan_o,
    output logic [23:0]      sample_data_o,
    output logic             frame_lock_o
);
    localparam int LINES = msa_pkg::MSA_LINES;
    localparam int WW    = msa_pkg::MSA_WORD_W;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] slots_of(input logic [2:0] m);
        case (m)
            msa_pkg::MSA_MODE_TDM4:  slots_of = 5'h04;
            msa_pkg::MSA_MODE_TDM8:  slots_of = 5'h08;
            msa_pkg::MSA_MODE_TDM16: slots_of = 5'h10;
            default:                 slots_of = 5'h02;
        endcase
    endfunction

    function automatic logic [3:0] lines_of(input logic [2:0] m);
        case (m)
            msa_pkg::MSA_MODE_TDM4:  lines_of = 4'h4;
            msa_pkg::MSA_MODE_TDM8:  lines_of = 4'h2;
            msa_pkg::MSA_MODE_TDM16: lines_of = 4'h1;
            default:                 lines_of = 4'h8;
        endcase
    endfunction

    function automatic logic [3:0] chan_of(input logic [2:0] ln,
                                           input logic [4:0] spl,
                                           input logic [3:0] sl);
        logic [7:0] p;
        p = {5'h00, ln} * {3'h0, spl} + {4'h0, sl};
        chan_of = p[3:0];
    endfunction

    // ****************************************
    // control capture
    // ****************************************
    logic [7:0]               ctrl0_r;
    logic [7:0]               ctrl1_r;
    msa_pkg::msa_fmt_type     fmt;
    logic [2:0]               mode;
    logic                     master;
    logic                     edge_fall;
    logic                     fpol;
    logic                     fpulse;
    logic [5:0]               slot_len;
    logic [4:0]               spl;
    logic [3:0]               nlines;
    logic [9:0]               frame_len;

    // reset constants put the port in I2S slave framing
    // default I2S framing
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl0_r <= msa_pkg::MSA_CTRL0_RST;
            ctrl1_r <= msa_pkg::MSA_CTRL1_RST;
        end else if (clk_en_i) begin
            ctrl0_r <= dac_control_zero_i;
            ctrl1_r <= dac_control_one_i;
        end
    end

    // field decode
    // mode field decode
    assign fmt       = msa_pkg::msa_fmt_type'(ctrl0_r[msa_pkg::MSA_FMT_LSB +: 2]);
    assign mode      = ctrl0_r[msa_pkg::MSA_MODE_LSB +: 3];
    assign master    = ctrl1_r[msa_pkg::MSA_MS_BIT];
    assign edge_fall = ctrl1_r[msa_pkg::MSA_EDGE_BIT];
    assign fpol      = ctrl1_r[msa_pkg::MSA_POL_BIT];
    assign fpulse    = ctrl1_r[msa_pkg::MSA_LRMODE_BIT];
    assign slot_len  = ctrl1_r[msa_pkg::MSA_RATE_BIT] ?
                       msa_pkg::MSA_SLOT_SHORT : msa_pkg::MSA_SLOT_LONG;
    assign spl       = slots_of(mode);
    assign nlines    = lines_of(mode);
    assign frame_len = {5'h00, spl} * {4'h0, slot_len};

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic       bclk_s1_r;
    logic       bclk_s2_r;
    logic       fr_s1_r;
    logic       fr_s2_r;
    logic [7:0] dat_s1_r;
    logic [7:0] dat_s2_r;

    // data shares the clocks' latency so edges and bits stay aligned
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bclk_s1_r <= 1'b0;
            bclk_s2_r <= 1'b0;
            fr_s1_r   <= 1'b0;
            fr_s2_r   <= 1'b0;
            dat_s1_r  <= 8'h00;
            dat_s2_r  <= 8'h00;
        end else if (clk_en_i) begin
            bclk_s1_r <= dac_bit_clock_i;
            bclk_s2_r <= bclk_s1_r;
            fr_s1_r   <= dac_frame_clock_i;
            fr_s2_r   <= fr_s1_r;
            dat_s1_r  <= serial_data_in_i;
            dat_s2_r  <= dat_s1_r;
        end
    end

    // ****************************************
    // master clock generator
    // ****************************************
    logic [7:0] div_r;
    logic       gen_bclk_r;
    logic [9:0] gen_bit_r;
    logic       frame_out_r;

    // data advances on the edge opposite the capture edge
    // master clock drive
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_r      <= 8'h00;
            gen_bclk_r <= 1'b0;
            gen_bit_r  <= 10'h000;
        end else if (clk_en_i) begin
            if (!master) begin
                div_r      <= 8'h00;
                gen_bclk_r <= 1'b0;
                gen_bit_r  <= 10'h000;
            end else if (div_r == 8'(HALF_CYC - 1)) begin
                div_r      <= 8'h00;
                gen_bclk_r <= ~gen_bclk_r;
                if (~gen_bclk_r == edge_fall) begin
                    gen_bit_r <= (gen_bit_r >= frame_len - 10'h001) ?
                                 10'h000 : gen_bit_r + 10'h001;
                end
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // frame shape: one bit wide, or high for the first half
    // frame shape
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_out_r <= 1'b0;
        end else if (clk_en_i) begin
            frame_out_r <= (fpulse ? (gen_bit_r == 10'h000)
                                   : (gen_bit_r < (frame_len >> 1))) ^ fpol;
        end
    end

    // both pins turn round together
    // pin direction
    assign dac_bit_clock_o        = gen_bclk_r;
    assign dac_frame_clock_o      = frame_out_r;
    assign dac_bit_clock_oe_b_o   = ~master;
    assign dac_frame_clock_oe_b_o = ~master;

    // ****************************************
    // receiver timing
    // ****************************************
    logic       bck;
    logic       frm_lvl;
    logic       bck_prev_r;
    logic       frm_prev_r;
    logic       act;
    logic       fstart;
    logic       locked_r;
    logic [5:0] bit_cnt_r;
    logic [3:0] slot_r;
    logic [5:0] cur_bit;
    logic [3:0] cur_slot;
    logic [5:0] start_pos;
    logic [5:0] wlen;
    logic       in_win;
    logic       slot_end;

    // one bit clock and one frame clock for every line
    // shared clock pair
    assign bck     = master ? gen_bclk_r : bclk_s2_r;
    assign frm_lvl = (master ? frame_out_r : fr_s2_r) ^ fpol;
    assign act     = (bck != bck_prev_r) && (bck != edge_fall);
    assign fstart  = act && frm_lvl && !frm_prev_r;
    assign cur_bit  = fstart ? 6'h00 : bit_cnt_r;
    assign cur_slot = fstart ? 4'h0 : slot_r;

    // where the word sits inside its slot
    // justification
    always_comb begin
        wlen = (fmt == msa_pkg::MSA_FMT_RJ16) ?
               msa_pkg::MSA_LEN_SHORT : msa_pkg::MSA_LEN_LONG;
        case (fmt)
            msa_pkg::MSA_FMT_I2S:  start_pos = msa_pkg::MSA_I2S_DELAY;
            msa_pkg::MSA_FMT_LJ:   start_pos = 6'h00;
            msa_pkg::MSA_FMT_RJ24: start_pos = (slot_len > wlen) ?
                                               slot_len - wlen : 6'h00;
            default:               start_pos = slot_len - wlen;
        endcase
    end

    assign in_win   = (cur_bit >= start_pos) && (cur_bit < start_pos + wlen);
    assign slot_end = act && (cur_bit == slot_len - 6'h01)
                      && (locked_r || fstart);

    // counters realign on each frame start
    // frame realignment
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bck_prev_r <= 1'b0;
            frm_prev_r <= 1'b0;
            locked_r   <= 1'b0;
            bit_cnt_r  <= 6'h00;
            slot_r     <= 4'h0;
        end else if (clk_en_i) begin
            bck_prev_r <= bck;
            if (act) begin
                frm_prev_r <= frm_lvl;
                if (fstart) begin
                    locked_r <= 1'b1;
                end
                if (slot_end) begin
                    bit_cnt_r <= 6'h00;
                    slot_r    <= (cur_slot == 4'(spl - 5'h01)) ?
                                 4'h0 : cur_slot + 4'h1;
                end else begin
                    bit_cnt_r <= cur_bit + 6'h01;
                    slot_r    <= cur_slot;
                end
            end
        end
    end

    // ****************************************
    // shift registers and store walker
    // ****************************************
    logic [WW-1:0] sh_r   [LINES];
    logic [WW-1:0] sh_nxt [LINES];
    logic [WW-1:0] hold_r [LINES];
    logic [3:0]    hold_slot_r;
    logic [2:0]    line_r;
    logic [3:0]    chan;
    msa_pkg::msa_wr_state_type wr_state_r;

    // slot start clears, bits in the window shift in msb first
    always_comb begin
        for (int l = 0; l < LINES; l++) begin
            sh_nxt[l] = (cur_bit == 6'h00) ? '0 : sh_r[l];
            if (in_win) begin
                sh_nxt[l] = {sh_nxt[l][WW-2:0], dat_s2_r[l]};
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int l = 0; l < LINES; l++) begin
                sh_r[l]   <= '0;
                hold_r[l] <= '0;
            end
            hold_slot_r <= 4'h0;
        end else if (clk_en_i && act) begin
            for (int l = 0; l < LINES; l++) begin
                sh_r[l] <= sh_nxt[l];
                if (slot_end) begin
                    hold_r[l] <= (fmt == msa_pkg::MSA_FMT_RJ16) ?
                                 {sh_nxt[l][15:0], 8'h00} : sh_nxt[l];
                end
            end
            if (slot_end) begin
                hold_slot_r <= cur_slot;
            end
        end
    end

    // one store write per active line; a new slot restarts the walk
    // line mapping for every mode
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_state_r <= msa_pkg::MSA_WR_IDLE;
            line_r     <= 3'h0;
        end else if (clk_en_i) begin
            case (wr_state_r)
                msa_pkg::MSA_WR_IDLE: begin
                    if (slot_end) begin
                        wr_state_r <= msa_pkg::MSA_WR_BUSY;
                        line_r     <= 3'h0;
                    end
                end
                msa_pkg::MSA_WR_BUSY: begin
                    if (slot_end) begin
                        line_r <= 3'h0;
                    end else if ({1'b0, line_r} == nlines - 4'h1) begin
                        wr_state_r <= msa_pkg::MSA_WR_IDLE;
                    end else begin
                        line_r <= line_r + 3'h1;
                    end
                end
                default: wr_state_r <= msa_pkg::MSA_WR_IDLE;
            endcase
        end
    end

    assign chan = chan_of(line_r, spl, hold_slot_r);

    // sample strobe mirrors each store write
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_valid_o <= 1'b0;
            sample_chan_o  <= 4'h0;
            sample_data_o  <= 24'h000000;
        end else if (clk_en_i) begin
            sample_valid_o <= (wr_state_r == msa_pkg::MSA_WR_BUSY);
            sample_chan_o  <= chan;
            sample_data_o  <= hold_r[line_r];
        end
    end

    msa_mem_if mif ();

    assign mif.wr_en   = (wr_state_r == msa_pkg::MSA_WR_BUSY);
    assign mif.wr_addr = chan;
    assign mif.wr_data = hold_r[line_r];
    assign mif.rd_addr = rd_chan_i;
    assign rd_data_o   = mif.rd_data;
    assign frame_lock_o = locked_r;

    msa_sample_mem u_mem (
        .clock_i  (clock_i),
        .rst_b_i  (rst_b_i),
        .clk_en_i (clk_en_i),
        .mem      (mif)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_frame_restart: assert property (clk_en_i && fstart && !slot_end
        |=> bit_cnt_r == 6'h01 && slot_r == 4'h0)
        else $error("frame start did not restart counting");
    a_slot_wrap: assert property (clk_en_i && slot_end
        |=> bit_cnt_r == 6'h00)
        else $error("slot did not end at its length");
    a_i2s_delay: assert property (fstart && fmt == msa_pkg::MSA_FMT_I2S
        |-> !in_win)
        else $error("i2s bit taken on the frame edge");
    a_rj16_start: assert property (act && fmt == msa_pkg::MSA_FMT_RJ16
        && cur_bit == slot_len - 6'h10 |-> in_win)
        else $error("right-justified word start wrong");
    a_capture_edge: assert property (clk_en_i && act && in_win
        |=> sh_r[0][0] == $past(dat_s2_r[0]))
        else $error("capture missed the synchronised data bit");
    a_slave_pins: assert property (!ctrl1_r[msa_pkg::MSA_MS_BIT]
        |-> dac_bit_clock_oe_b_o && dac_frame_clock_oe_b_o)
        else $error("slave port drives a clock pin");
    a_line_limit: assert property (mif.wr_en |-> {1'b0, line_r} < nlines)
        else $error("ignored data line was stored");
    a_walk_end: assert property (clk_en_i && !slot_end
        && wr_state_r == msa_pkg::MSA_WR_BUSY
        && {1'b0, line_r} == nlines - 4'h1
        |=> wr_state_r == msa_pkg::MSA_WR_IDLE)
        else $error("store walk overran its lines");
    a_strobe_follow: assert property (clk_en_i && mif.wr_en
        |=> sample_valid_o && sample_chan_o == $past(chan))
        else $error("sample strobe lost a store write");

    c_stereo_frame: cover property (fstart && mode == 3'h0);
    c_tdm16_write:  cover property (mif.wr_en && mode == 3'h4
                                    && chan == 4'hF);
    c_master_fall:  cover property (master && edge_fall && slot_end);
endmodule

// >>> rtl/msa_pkg.sv
package msa_pkg;
    // ****************************************
    // sizes of the port
    // ****************************************
    localparam int MSA_CHANNELS = 16;
    localparam int MSA_LINES    = 8;
    localparam int MSA_WORD_W   = 24;
    localparam int MSA_CHAN_W   = 4;

    // ****************************************
    // slot and word lengths in bit clocks
    // ****************************************
    localparam logic [5:0] MSA_SLOT_LONG  = 6'h20;
    localparam logic [5:0] MSA_SLOT_SHORT = 6'h10;
    localparam logic [5:0] MSA_LEN_LONG   = 6'h18;
    localparam logic [5:0] MSA_LEN_SHORT  = 6'h10;
    localparam logic [5:0] MSA_I2S_DELAY  = 6'h01;

    // ****************************************
    // control field positions and reset values
    // ****************************************
    localparam int MSA_FMT_LSB    = 6;  // control zero [7:6]
    localparam int MSA_MODE_LSB   = 3;  // control zero [5:3]
    localparam int MSA_MS_BIT     = 0;  // control one: clock master
    localparam int MSA_EDGE_BIT   = 1;  // control one: falling edge
    localparam int MSA_RATE_BIT   = 2;  // control one: 16-bit slots
    localparam int MSA_POL_BIT    = 5;  // control one: frame inverted
    localparam int MSA_LRMODE_BIT = 6;  // control one: pulse frame
    localparam logic [7:0] MSA_CTRL0_RST = 8'h01;
    localparam logic [7:0] MSA_CTRL1_RST = 8'h00;

    // master bit clock half period in system clocks
    localparam int MSA_HALF_CYC = 6;

    typedef enum logic [1:0] {
        MSA_FMT_I2S  = 2'h0,
        MSA_FMT_LJ   = 2'h1,
        MSA_FMT_RJ24 = 2'h2,
        MSA_FMT_RJ16 = 2'h3
    } msa_fmt_type;

    typedef enum logic [2:0] {
        MSA_MODE_ST0   = 3'h0,
        MSA_MODE_ST1   = 3'h1,
        MSA_MODE_TDM4  = 3'h2,
        MSA_MODE_TDM8  = 3'h3,
        MSA_MODE_TDM16 = 3'h4
    } msa_mode_type;

    typedef enum logic {
        MSA_WR_IDLE = 1'b0,
        MSA_WR_BUSY = 1'b1
    } msa_wr_state_type;
endpackage

// >>> rtl/msa_mem_if.sv
`timescale 1ns/1ps
// write and read path between the port and its sample store
interface msa_mem_if;
    logic                          wr_en;
    logic [msa_pkg::MSA_CHAN_W-1:0] wr_addr;
    logic [msa_pkg::MSA_WORD_W-1:0] wr_data;
    logic [msa_pkg::MSA_CHAN_W-1:0] rd_addr;
    logic [msa_pkg::MSA_WORD_W-1:0] rd_data;

    modport writer (output wr_en, wr_addr, wr_data, rd_addr,
                    input  rd_data);
    modport store  (input  wr_en, wr_addr, wr_data, rd_addr,
                    output rd_data);
endinterface

// >>> rtl/msa_sample_mem.sv
`timescale 1ns/1ps
// latest sample of every channel, read data registered
module msa_sample_mem (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic clk_en_i,
    msa_mem_if.store  mem
);
    logic [msa_pkg::MSA_WORD_W-1:0] store_r [msa_pkg::MSA_CHANNELS];
    logic [msa_pkg::MSA_WORD_W-1:0] rd_data_r;

    // array has no reset: contents are audio, not control
    always_ff @(posedge clock_i) begin
        if (clk_en_i && mem.wr_en) begin
            store_r[mem.wr_addr] <= mem.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_r <= '0;
        end else if (clk_en_i) begin
            rd_data_r <= store_r[mem.rd_addr];
        end
    end

    assign mem.rd_data = rd_data_r;
endmodule

// >>> sim/msa_source_model.sv
`timescale 1ns/1ps
// ****************************************
// audio source driving the serial pins
// ****************************************
module msa_source_model (
    output logic       dac_bit_clock_o,
    output logic       dac_frame_clock_o,
    output logic [7:0] serial_data_o
);
    // a 64 ns bit clock keeps every mode under its rate cap
    localparam realtime HALF_NS = 32.0;

    // parks the pins; the clock rests at its post-capture level
    task automatic idle(input bit fall, input bit inv);
        dac_bit_clock_o   = ~fall;
        dac_frame_clock_o = inv;
    endtask

    // bit of a slot, word window set by the format
    function automatic logic pick(input int slen, input int fmt,
                                  input int b, input logic [23:0] w);
        int p;
        int wid;
        wid = (fmt == 3) ? 16 : 24;
        p = (fmt == 0) ? b - 1 : (fmt == 1) ? b : b - (slen - wid);
        // bits outside the word toggle so stale values never help
        return (p >= 0 && p < wid) ? w[23 - p] : b[0];
    endfunction

    // one clock pair frames every line
    task automatic send_frame(input int slots, input int slen,
                              input int fmt, input bit pulse,
                              input bit inv, input bit fall,
                              input logic [23:0] w [16]);
        int len;
        len = slots * slen;
        for (int n = 0; n < len; n++) begin
            dac_bit_clock_o = fall;
            dac_frame_clock_o = (pulse ? (n == 0) : (n < len / 2)) ^ inv;
            for (int l = 0; l < 8; l++)
                serial_data_o[l] = pick(slen, fmt, n % slen,
                                        w[(l * slots + n / slen) % 16]);
            #HALF_NS;
            dac_bit_clock_o = ~fall;
            #HALF_NS;
        end
        // released lines flip so nothing is held by accident
        serial_data_o = ~serial_data_o;
    endtask

    initial begin
        serial_data_o = 8'h00;
        idle(1'b0, 1'b0);
    end
endmodule

// >>> sim/msa_serial_port_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ****************************************
// self-checking bench of the serial port
// ****************************************
module msa_serial_port_bench;
    localparam int HALF = msa_pkg::MSA_HALF_CYC;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  ctrl0 = 8'h01;
    logic [7:0]  ctrl1 = 8'h00;
    logic [3:0]  rd_chan = 4'h0;
    logic        src_bclk, src_fclk, bclk_o, bclk_oe_b, fclk_o, fclk_oe_b;
    logic        valid, lock, b;
    logic [7:0]  sdata;
    logic [3:0]  chan;
    logic [23:0] rd_data, data;
    logic [27:0] expq [$];
    logic [27:0] note;
    logic [23:0] last [16];
    logic [23:0] w [16];
    logic [31:0] seed = 32'h0000B871;
    logic [8:0]  cfgs [6] = '{9'h000, 9'h0A2, 9'h135, 9'h1CE, 9'h199, 9'h0D4};
    int          num_errors = 0;
    int          compares = 0;
    int          t;

    always #2.5 clock_i = ~clock_i;

    msa_source_model i_msa_source_model (.dac_bit_clock_o(src_bclk),
        .dac_frame_clock_o(src_fclk), .serial_data_o(sdata));

    // pins resolve to whichever side has its driver enabled
    msa_serial_port #(.HALF_CYC(HALF)) i_msa_serial_port (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .dac_control_zero_i(ctrl0), .dac_control_one_i(ctrl1),
        .dac_bit_clock_i(bclk_oe_b ? src_bclk : bclk_o),
        .dac_bit_clock_o(bclk_o), .dac_bit_clock_oe_b_o(bclk_oe_b),
        .dac_frame_clock_i(fclk_oe_b ? src_fclk : fclk_o),
        .dac_frame_clock_o(fclk_o), .dac_frame_clock_oe_b_o(fclk_oe_b),
        .serial_data_in_i(sdata), .rd_chan_i(rd_chan), .rd_data_o(rd_data),
        .sample_valid_o(valid), .sample_chan_o(chan),
        .sample_data_o(data), .frame_lock_o(lock));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic test_done();
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // oldest note is matched against each stored sample
    always @(negedge clock_i) begin
        if (valid === 1'b1) begin
            if (expq.size() == 0)
                `CHK(valid, 1'b0)
            else begin
                // pop once: the macro reads its arguments twice
                note = expq.pop_front();
                `CHK({chan, data}, note)
            end
        end
    end

    // fields: fmt[8:7] mode[6:4] short[3] pulse[2] inv[1] fall[0]
    task automatic run_cfg(input logic [8:0] c);
        int slots;
        int e;
        logic [23:0] x;
        slots = (c[6:4] == 3'h2) ? 4 : (c[6:4] == 3'h3) ? 8 :
                (c[6:4] == 3'h4) ? 16 : 2;
        @(negedge clock_i);
        ctrl0 <= {c[8:7], c[6:4], 3'h1};
        ctrl1 <= {1'b0, c[2], c[1], 2'h0, c[3], c[0], 1'b0};
        i_msa_source_model.idle(c[0], c[1]);
        repeat (20) @(negedge clock_i);
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 16; k++) begin
                seed = xs(seed);
                w[k] = seed[23:0];
            end
            for (int s = 0; s < slots; s++)
                for (int l = 0; l < 16 / slots; l++) begin
                    e = l * slots + s;
                    x = (c[8:7] == 2'h3) ? {w[e][23:8], 8'h00} : w[e];
                    expq.push_back({4'(e), x});
                    last[e] = x;
                end
            i_msa_source_model.send_frame(slots, c[3] ? 16 : 32, c[8:7],
                                          c[2], c[1], c[0], w);
        end
        e = 0;
        while (expq.size() != 0 && e < 200) begin
            @(negedge clock_i);
            e++;
        end
        if (expq.size() != 0) begin
            num_errors++;
            test_done();
        end
        // readback of every channel, one cycle of latency
        for (int k = 0; k < 16; k++) begin
            rd_chan <= 4'(k);
            repeat (2) @(negedge clock_i);
            `CHK(rd_data, last[k])
        end
    endtask

    initial begin
        repeat (10) @(negedge clock_i);
        `CHK({bclk_oe_b, fclk_oe_b, lock, valid}, 4'hC)
        rst_b_i <= 1'b1;
        for (int i = 0; i < 6; i++)
            run_cfg(cfgs[i]);
        `CHK(lock, 1'b1)
        // master frame one stores the parked lines as all-ones or all-zeros
        for (int s = 0; s < 2; s++)
            for (int l = 0; l < 8; l++)
                expq.push_back({4'(l * 2 + s), {24{sdata[l]}}});
        // master mode: both pins driven, pulse frame one bit wide
        @(negedge clock_i);
        ctrl1 <= 8'h41;
        repeat (4) @(negedge clock_i);
        `CHK({bclk_oe_b, fclk_oe_b}, 2'h0)
        for (int r = 0; r < 2; r++) begin
            b = bclk_o;
            t = 0;
            while (bclk_o === b && t < 50) begin
                @(negedge clock_i);
                t++;
            end
        end
        `CHK(t, HALF)
        // frame out idles high before master starts; skip that level
        t = 0;
        while (fclk_o === 1'b1 && t < 2000) begin
            @(negedge clock_i);
            t++;
        end
        t = 0;
        while (fclk_o !== 1'b1 && t < 2000) begin
            @(negedge clock_i);
            t++;
        end
        t = 0;
        while (fclk_o === 1'b1 && t < 2000) begin
            @(negedge clock_i);
            t++;
        end
        `CHK(t, 2 * HALF)
        `CHK(expq.size(), 0)
        test_done();
    end
endmodule
